/* cmd_delay_line.v */
`timescale 1ns/1ps
module cmd_delay_line #(
	parameter W     = 2,
	parameter DEPTH = 15,
	parameter TW    = 4
) (
	input  wire          i_clk,
	input  wire          i_rst_b,
	input  wire [TW-1:0] i_delay,
	input  wire [W-1:0]  i_in,
	output wire [W-1:0]  o_out
);

reg  [W-1:0]  stage_r [0:DEPTH-1];
wire [TW-1:0] tap;

////////////////////////////////////////////////////////////////////////
// shift stages
genvar k;
generate
	for (k = 0; k < DEPTH; k = k + 1) begin : g_stage
		always @(posedge i_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				stage_r[k] <= {W{1'b0}};
			end else if (k == 0) begin
				stage_r[k] <= i_in;
			end else begin
				stage_r[k] <= stage_r[k-1];
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// tap select, zero delay passes straight through
assign tap   = i_delay - {{(TW-1){1'b0}}, 1'b1};
assign o_out = (i_delay == {TW{1'b0}}) ? i_in :
               (i_delay > DEPTH) ? {W{1'b0}} : stage_r[tap];

endmodule

/* ctl_model.sv */
`timescale 1ns/1ps
module ctl_model (
	input  wire        i_clk,
	output reg         o_load,
	output reg         o_rd,
	output reg         o_wr,
	output reg  [1:0]  o_ba,
	output reg         o_ba2,
	output reg  [15:0] o_addr,
	output reg         o_odt,
	output reg  [2:0]  o_pm
);
initial begin
	{o_load, o_rd, o_wr, o_ba, o_ba2, o_odt, o_pm} = 10'h0;
	o_addr = 16'h0;
end
////////////////////////////////////////////////////////////////////////
task load(input [1:0] b, input [12:0] w);
	begin
		@(posedge i_clk);
		o_load <= 1'h1;
		o_ba <= b;
		o_ba2 <= 1'h0;
		o_addr <= {3'h0, w};
		@(posedge i_clk);
		o_load <= 1'h0;
		o_ba <= ~b;
		o_addr <= ~o_addr;
		repeat (8) @(posedge i_clk);
	end
endtask
task cmd(input r, input w);
	begin
		@(posedge i_clk);
		o_rd <= r;
		o_wr <= w;
	end
endtask
task line(input t, input [2:0] m);
	begin
		@(posedge i_clk);
		o_odt <= t;
		o_pm <= m;
	end
endtask
endmodule

/* dram_ext_cfg_defs.vh */
`ifndef DRAM_EXT_CFG_DEFS_VH
`define DRAM_EXT_CFG_DEFS_VH

// configuration word load targets, {bank bit one, bank bit zero}
`define BANK_WORD_ONE     2'h1
`define BANK_WORD_TWO     2'h2
`define BANK_WORD_THREE   2'h3

// field positions in the loaded address word
`define WORD_BITS         13
`define TSEL_LO_BIT       2
`define TSEL_HI_BIT       6
`define POSTED_LSB        3
`define POSTED_MSB        5
`define CAL_LSB           7
`define CAL_MSB           9
`define RATE_BIT          7

// termination select codes, {high bit, low bit}
`define TERM_DISABLED     2'h0
`define TERM_75_OHM       2'h1
`define TERM_150_OHM      2'h2
`define TERM_50_OHM       2'h3

// reset values and column delay limits
`define WORD_ONE_RESET    13'h0000
`define RATE_RESET        1'h0
`define COL_DELAY_RESET   3'h3
`define COL_DELAY_MIN     3'h3
`define COL_DELAY_MAX     3'h7

// termination hold after word one enables it, in clocks
`define TERM_HOLD_CYC     4'h8

// power mode codes on the mode input
`define PM_ACTIVE         3'h0
`define PM_APD_FAST       3'h1
`define PM_APD_SLOW       3'h2
`define PM_PRE_PD         3'h3
`define PM_SELF_REFRESH   3'h4
`define PM_INIT           3'h5

// register byte offsets
`define REG_CTRL          5'h00
`define REG_WORD_ONE      5'h04
`define REG_WORD_TWO      5'h08
`define REG_WORD_THREE    5'h0c
`define REG_STATUS        5'h10

// control register fields
`define CTRL_COL_LSB      0
`define CTRL_COL_MSB      2

`endif

/* dram_ext_mode_config.v */
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dram_ext_cfg_defs.vh"

// How it works
// - termination value from two select bits of word one: 50, 75, 150 ohm
// - with termination enabled, control input level switches it on and off
// - control input honoured only in active and the three power-down modes
// - posted delay from three bits of word one, 0 to 6 clocks; the code also accepts field value 7 as 7 clocks
// - read or write held posted delay clocks before internal execution
// - read data appears after posted delay plus column access delay
// - write data delay equals total read delay minus one clock
// - word two holds only the refresh rate bit, rest reserved
// - words two and three kept until reload; reload spares the array; the code keeps no bits of word three
// - word three bits are reserved and have no function
// - bank bit zero high, bit one low loads word one
// - bank bit zero low, bit one high loads word two
// - both bank bits high loads word three
// - column access delay programmable 3 to 7 clocks
module dram_ext_mode_config #(
	parameter DEPTH = 15
) (
	input  wire        i_clk,
	input  wire        i_rst_b,
	input  wire        i_load_config_command,
	input  wire        i_cmd_read,
	input  wire        i_cmd_write,
	input  wire        i_bank_select_bit_zero,
	input  wire        i_bank_select_bit_one,
	input  wire        i_bank_select_bit_two,
	input  wire [15:0] i_addr,
	input  wire        i_termination_control_input,
	input  wire [2:0]  i_power_mode,
	input  wire [4:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	output reg  [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest,
	output reg         o_term_on,
	output reg  [1:0]  o_effective_termination_resistance,
	output reg         o_refresh_rate_bit,
	output wire        o_exec_read,
	output wire        o_exec_write,
	output wire        o_read_data_valid,
	output wire        o_write_data_capture
);

localparam [2:0] ST_OFF  = 3'b001;
localparam [2:0] ST_HOLD = 3'b010;
localparam [2:0] ST_LIVE = 3'b100;

reg  [`WORD_BITS-1:0] word_one_r;
reg                   ack_r;
reg  [2:0]            col_delay_r;
reg  [2:0]            term_state_r;
reg  [2:0]            term_state_nxt;
reg  [3:0]            hold_cnt_r;
reg  [3:0]            hold_cnt_nxt;
reg                   term_on_nxt;
reg                   mode_ok;
reg  [31:0]           rdata_nxt;

wire [1:0]            bank_pair;
wire                  load_one;
wire                  load_two;
wire [1:0]            term_sel;
wire                  term_en_new;
wire [2:0]            posted_delay;
wire [3:0]            total_read_delay;
wire [3:0]            write_data_delay;
wire                  bus_req;
wire                  bus_wr;

////////////////////////////////////////////////////////////////////////
// configuration word load decode
assign bank_pair = {i_bank_select_bit_one, i_bank_select_bit_zero};
assign load_one  = i_load_config_command &
                   (bank_pair == `BANK_WORD_ONE);
assign load_two  = i_load_config_command &
                   (bank_pair == `BANK_WORD_TWO);

// word three load, both bank bits high, has no effect

always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		word_one_r <= `WORD_ONE_RESET;
	end else if (load_one) begin
		word_one_r <= i_addr[`WORD_BITS-1:0];
	end
end

// only the refresh rate bit of word two is kept
always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_refresh_rate_bit <= `RATE_RESET;
	end else if (load_two) begin
		o_refresh_rate_bit <= i_addr[`RATE_BIT];
	end
end

////////////////////////////////////////////////////////////////////////
// termination select and posted delay fields
assign term_sel     = {word_one_r[`TSEL_HI_BIT],
                       word_one_r[`TSEL_LO_BIT]};
assign term_en_new  = ({i_addr[`TSEL_HI_BIT], i_addr[`TSEL_LO_BIT]} !=
                       `TERM_DISABLED);
assign posted_delay = word_one_r[`POSTED_MSB:`POSTED_LSB];

// latency arithmetic
assign total_read_delay = {1'b0, posted_delay} +
                          {1'b0, col_delay_r};
assign write_data_delay = total_read_delay - 4'h1;

////////////////////////////////////////////////////////////////////////
// termination power mode gate
always @* begin
	case (i_power_mode)
		`PM_ACTIVE:   mode_ok = 1'b1;
		`PM_APD_FAST: mode_ok = 1'b1;
		`PM_APD_SLOW: mode_ok = 1'b1;
		`PM_PRE_PD:   mode_ok = 1'b1;
		default:      mode_ok = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////
// termination state machine
always @* begin
	term_state_nxt = term_state_r;
	hold_cnt_nxt   = hold_cnt_r;
	case (term_state_r)
		ST_OFF: begin
			hold_cnt_nxt = 4'h0;
		end
		ST_HOLD: begin
			// input is held low by the controller here
			if (hold_cnt_r == `TERM_HOLD_CYC - 4'h1) begin
				term_state_nxt = ST_LIVE;
			end else begin
				hold_cnt_nxt = hold_cnt_r + 4'h1;
			end
		end
		ST_LIVE: begin
			hold_cnt_nxt = 4'h0;
		end
		default: begin
			term_state_nxt = ST_OFF;
			hold_cnt_nxt   = 4'h0;
		end
	endcase
	if (load_one) begin
		hold_cnt_nxt = 4'h0;
		if (term_en_new) begin
			term_state_nxt = ST_HOLD;
		end else begin
			term_state_nxt = ST_OFF;
		end
	end
end

// termination output, off until word one enables it
always @* begin
	term_on_nxt = 1'b0;
	if (term_state_r != ST_OFF && mode_ok) begin
		term_on_nxt = i_termination_control_input;
	end
end

always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		term_state_r <= ST_OFF;
		hold_cnt_r   <= 4'h0;
		o_term_on    <= 1'b0;
		o_effective_termination_resistance <= `TERM_DISABLED;
	end else begin
		term_state_r <= term_state_nxt;
		hold_cnt_r   <= hold_cnt_nxt;
		o_term_on    <= term_on_nxt;
		o_effective_termination_resistance <= term_sel;
	end
end

////////////////////////////////////////////////////////////////////////
// posted command delay before internal execution
cmd_delay_line #(
	.W     (2),
	.DEPTH (DEPTH),
	.TW    (4)
) u_posted (
	.i_clk   (i_clk),
	.i_rst_b (i_rst_b),
	.i_delay ({1'b0, posted_delay}),
	.i_in    ({i_cmd_write, i_cmd_read}),
	.o_out   ({o_exec_write, o_exec_read})
);

// read data valid at total read delay
cmd_delay_line #(
	.W     (1),
	.DEPTH (DEPTH),
	.TW    (4)
) u_read (
	.i_clk   (i_clk),
	.i_rst_b (i_rst_b),
	.i_delay (total_read_delay),
	.i_in    (i_cmd_read),
	.o_out   (o_read_data_valid)
);

// write data capture at write data delay
cmd_delay_line #(
	.W     (1),
	.DEPTH (DEPTH),
	.TW    (4)
) u_write (
	.i_clk   (i_clk),
	.i_rst_b (i_rst_b),
	.i_delay (write_data_delay),
	.i_in    (i_cmd_write),
	.o_out   (o_write_data_capture)
);

////////////////////////////////////////////////////////////////////////
// bus slave, one wait cycle per access
assign bus_req           = i_avs_read | i_avs_write;
assign o_avs_waitrequest = bus_req & ~ack_r;
assign bus_wr            = i_avs_write & ack_r;

always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		ack_r <= 1'b0;
	end else begin
		ack_r <= bus_req & ~ack_r;
	end
end

// column access delay, out of range writes ignored
always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		col_delay_r <= `COL_DELAY_RESET;
	end else if (bus_wr && i_avs_address == `REG_CTRL) begin
		if (i_avs_writedata[`CTRL_COL_MSB:`CTRL_COL_LSB] >=
		    `COL_DELAY_MIN) begin
			col_delay_r <= i_avs_writedata[`CTRL_COL_MSB:`CTRL_COL_LSB];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// read mux
always @* begin
	rdata_nxt = 32'h0000_0000;
	case (i_avs_address)
		`REG_CTRL: begin
			rdata_nxt[`CTRL_COL_MSB:`CTRL_COL_LSB] = col_delay_r;
		end
		`REG_WORD_ONE: begin
			rdata_nxt[`WORD_BITS-1:0] = word_one_r;
		end
		`REG_WORD_TWO: begin
			rdata_nxt[`RATE_BIT] = o_refresh_rate_bit;
		end
		`REG_WORD_THREE: begin
			rdata_nxt = 32'h0000_0000;
		end
		`REG_STATUS: begin
			rdata_nxt[0]     = o_term_on;
			rdata_nxt[3:1]   = term_state_r;
			rdata_nxt[7:4]   = total_read_delay;
			rdata_nxt[11:8]  = write_data_delay;
			rdata_nxt[14:12] = posted_delay;
			rdata_nxt[15]    = mode_ok;
		end
		default: begin
			rdata_nxt = 32'h0000_0000;
		end
	endcase
end

always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_avs_readdata <= 32'h0000_0000;
	end else if (i_avs_read && !ack_r) begin
		o_avs_readdata <= rdata_nxt;
	end
end

endmodule

/* dram_ext_mode_config_props.sv */
`timescale 1ns/1ps
module dram_ext_mode_config_props #(
	parameter DEPTH = 15
) (
	input wire        i_clk, i_rst_b, i_load_config_command,
	input wire        i_cmd_read, i_cmd_write,
	input wire        i_bank_select_bit_zero, i_bank_select_bit_one,
	input wire [15:0] i_addr,
	input wire        i_termination_control_input,
	input wire [2:0]  i_power_mode,
	input wire [4:0]  i_avs_address,
	input wire        i_avs_write, i_avs_read,
	input wire [31:0] i_avs_writedata,
	input wire        o_avs_waitrequest, o_term_on, o_refresh_rate_bit,
	input wire [1:0]  o_effective_termination_resistance,
	input wire        o_exec_read, o_exec_write,
	input wire        o_read_data_valid, o_write_data_capture
);
////////////////////////////////////////////////////////////////////////
reg  [2:0]  al_r, col_r;
reg  [13:0] hr_r, hw_r;
wire [3:0]  rl = al_r + col_r;
wire [1:0]  ba = {i_bank_select_bit_one, i_bank_select_bit_zero};
wire        ld = i_load_config_command;
wire        cw = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h00;
always @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		al_r <= 3'h0;
		col_r <= 3'h3;
		hr_r <= 14'h0;
		hw_r <= 14'h0;
	end else begin
		if (ld && ba == 2'h1) al_r <= i_addr[5:3];
		if (cw && i_avs_writedata[2:0] >= 3'h3) col_r <= i_avs_writedata[2:0];
		hr_r <= {hr_r[12:0], i_cmd_read};
		hw_r <= {hw_r[12:0], i_cmd_write};
	end
end
////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_b);
chk_exec_rd: assert property (o_exec_read ==
	(al_r == 3'h0 ? i_cmd_read : hr_r[al_r - 3'h1])) else $error("rd exec");
chk_exec_wr: assert property (o_exec_write ==
	(al_r == 3'h0 ? i_cmd_write : hw_r[al_r - 3'h1])) else $error("wr exec");
chk_rd_valid: assert property (
	o_read_data_valid == hr_r[rl - 4'h1]) else $error("read delay");
chk_wr_capture: assert property (
	o_write_data_capture == hw_r[rl - 4'h2]) else $error("write delay");
chk_term_level: assert property (o_term_on |->
	$past(i_termination_control_input) &&
	o_effective_termination_resistance != 2'h0) else $error("term level");
chk_term_mode: assert property (
	o_term_on |-> $past(i_power_mode) <= 3'h3) else $error("term mode");
chk_term_sel: assert property (ld && ba == 2'h1 |=> ##1
	o_effective_termination_resistance == $past({i_addr[6], i_addr[2]}, 2))
	else $error("term select");
chk_rate_load: assert property (ld && ba == 2'h2 |=>
	o_refresh_rate_bit == $past(i_addr[7])) else $error("rate bit");
cov_read: cover property (o_read_data_valid);
cov_write: cover property (o_write_data_capture);
cov_term: cover property (o_term_on);
endmodule
bind dram_ext_mode_config dram_ext_mode_config_props #(.DEPTH(DEPTH)) u_props (.*);

/* tb_dram_ext_mode_config.sv */
`timescale 1ns/1ps
module tb_dram_ext_mode_config;
reg         i_clk = 1'h0, i_rst_b = 1'h0, rd = 1'h0, wr = 1'h0;
reg  [4:0]  adr = 5'h00;
reg  [31:0] wd = 32'h0, d;
reg  [3:0]  e [0:31];
wire [31:0] rdat;
wire [15:0] addr;
wire [2:0]  pm;
wire [1:0]  ba, eff;
wire        wreq, ld, cr, cw, b2, termination_control_input, ton, rate, xr, xw, rv, wc;
integer     fail_count = 0, samples_checked = 0, cyc = 0;
integer     al_m = 0, col_m = 3, seed = 32'h9de4, i, m, r;
initial begin
	forever #12.5 i_clk = ~i_clk;
end
ctl_model ctl_i (.i_clk(i_clk), .o_load(ld), .o_rd(cr), .o_wr(cw),
	.o_ba(ba), .o_ba2(b2), .o_addr(addr), .o_odt(termination_control_input), .o_pm(pm));
dram_ext_mode_config #(.DEPTH(15)) dram_ext_mode_config_i (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_load_config_command(ld),
	.i_cmd_read(cr), .i_cmd_write(cw), .i_bank_select_bit_zero(ba[0]),
	.i_bank_select_bit_one(ba[1]), .i_bank_select_bit_two(b2),
	.i_addr(addr), .i_termination_control_input(termination_control_input), .i_power_mode(pm),
	.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
	.i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
	.o_term_on(ton), .o_effective_termination_resistance(eff),
	.o_refresh_rate_bit(rate), .o_exec_read(xr), .o_exec_write(xw),
	.o_read_data_valid(rv), .o_write_data_capture(wc));
////////////////////////////////////////////////////////////////////////
task chk(input string nm, input [31:0] s, input [31:0] x);
	begin
		samples_checked = samples_checked + 1;
		if (s !== x) begin
			fail_count = fail_count + 1;
			$display("[FAIL] %s exp %h saw %h", nm, x, s);
		end
	end
endtask
task close_out;
	begin
		$display("checks %0d fails %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
endtask
task bus(input w, input [4:0] a, input [31:0] v);
	begin
		@(posedge i_clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= v;
		@(posedge i_clk);
		while (wreq !== 1'h0) begin
			@(posedge i_clk);
		end
		d = rdat;
		rd <= 1'h0;
		wr <= 1'h0;
		wd <= ~v;
	end
endtask
////////////////////////////////////////////////////////////////////////
always @(posedge i_clk) begin
	cyc <= cyc + 1;
	if (cyc == 5000) begin
		fail_count = fail_count + 1;
		close_out;
	end
end
always @(negedge i_clk) begin
	if (i_rst_b) begin
		if (ld && ba == 2'h1) al_m = addr[5:3];
		if (cr) e[(cyc + al_m) % 32][0] = 1'h1;
		if (cr) e[(cyc + al_m + col_m) % 32][2] = 1'h1;
		if (cw) e[(cyc + al_m) % 32][1] = 1'h1;
		if (cw) e[(cyc + al_m + col_m - 1) % 32][3] = 1'h1;
		chk("cmd", {wc, rv, xw, xr}, e[cyc % 32]);
		e[cyc % 32] = 4'h0;
	end
end
initial begin
	for (i = 0; i < 32; i = i + 1) e[i] = 4'h0;
	repeat (2) @(posedge i_clk);
	i_rst_b <= 1'h1;
	bus(1'h1, 5'h00, 32'h2);
	bus(1'h0, 5'h00, 32'h0);
	chk("ctrl", d, 32'h3);
	bus(1'h0, 5'h14, 32'h0);
	chk("unmap", d, 32'h0);
	chk("rate", rate, 32'h0);
	$display("test reset done");
	ctl_i.line(1'h0, 3'h5);
	ctl_i.load(2'h2, 13'h0080);
	chk("rate", rate, 32'h1);
	bus(1'h0, 5'h08, 32'h0);
	chk("word2", d, 32'h80);
	r = $random(seed);
	ctl_i.load(2'h3, r[12:0]);
	chk("rate", rate, 32'h1);
	bus(1'h0, 5'h0c, 32'h0);
	chk("word3", d, 32'h0);
	ctl_i.load(2'h1, 13'h0044);
	bus(1'h1, 5'h04, 32'h1fff);
	bus(1'h0, 5'h04, 32'h0);
	chk("word1", d, 32'h44);
	$display("test init done");
	for (i = 0; i < 4; i = i + 1) begin
		ctl_i.line(1'h0, 3'h0);
		ctl_i.load(2'h1, {6'h0, i[1], 3'h0, i[0], 2'h0});
		chk("eff", eff, i[1:0]);
		for (m = 0; m < 6; m = m + 1) begin
			ctl_i.line(1'h0, 3'h0);
			ctl_i.line(m != 4, m[2:0]);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			chk("term", ton, i != 0 && m <= 3);
		end
	end
	ctl_i.line(1'h0, 3'h0);
	$display("test term done");
	for (i = 0; i < 7; i = i + 1) begin
		col_m = 3 + i % 5;
		bus(1'h1, 5'h00, col_m);
		ctl_i.load(2'h1, {7'h0, i[2:0], 3'h0});
		bus(1'h0, 5'h10, 32'h0);
		chk("rl", d[7:4], i + col_m);
		chk("wl", d[11:8], i + col_m - 1);
		chk("al", d[14:12], i);
		chk("mode", d[15], 32'h1);
		repeat (24) begin
			r = $random(seed);
			ctl_i.cmd(r[0], r[1]);
		end
		ctl_i.cmd(1'h0, 1'h0);
		repeat (20) @(posedge i_clk);
	end
	$display("test delay done");
	close_out;
end
endmodule
